// ---- ppp_map.svh ----
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH

// action select codes sampled with each rising load strobe
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

// command byte codes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEEPROM 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REEPROM 8'h03

// array geometry
`define PPP_FLASH_AW 14
`define PPP_EE_AW 10
`define PPP_FWORD_BITS 6
`define PPP_EWORD_BITS 2
`define PPP_FLASH_LAST 14'h3FFF
`define PPP_EE_LAST 14'h03FF
`define PPP_FPAGE_LAST 14'h003F
`define PPP_EPAGE_LAST 14'h0003
`define PPP_FIFO_W 22
`define PPP_FIFO_DEPTH 8

// fuse and lock reset values, erased value, preserve fuse position
`define PPP_FUSE_LO_RST 8'hE1
`define PPP_FUSE_HI_RST 8'h99
`define PPP_LOCK_RST 8'hFF
`define PPP_ERASED 8'hFF
`define PPP_ERASED_WORD 16'hFFFF
`define PPP_PRESERVE_BIT 3

// self-timed operation times and clock rate
`define PPP_CLK_MHZ 25
`define PPP_T_WRITE_MS 3.7
`define PPP_T_ERASE_MS 7.5
`define PPP_WRITE_CYCLES (`PPP_T_WRITE_MS * 1000.0 * `PPP_CLK_MHZ)
`define PPP_ERASE_CYCLES (`PPP_T_ERASE_MS * 1000.0 * `PPP_CLK_MHZ)

`endif

// ---- ppp_pkg.sv ----
`include "ppp_map.svh"

package ppp_pkg;

  // controller states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DRAIN = 5'b00010,
    ST_PROG  = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_HOLD  = 5'b10000
  } ppp_state_t;

  // control state of the programming port; arrays and fifo are kept outside
  typedef struct packed {
    ppp_state_t state;
    logic [7:0] cmd;
    logic [7:0] opCmd;
    logic [7:0] addrLo;
    logic [7:0] addrHi;
    logic [7:0] dataLo;
    logic [7:0] dataHi;
    logic [7:0] fuseLo;
    logic [7:0] fuseHi;
    logic [7:0] lockBits;
    logic [7:0] rdData;
    logic strobePrev;
    logic latchPrev;
    logic writePrev;
    logic latchPend;
    logic eraseEe;
    logic erasePhase;
    logic [13:0] walk;
    logic [17:0] timer;
    logic [5:0] pendIdx;
    logic [15:0] pendWord;
  } ppp_regs_t;

endpackage

// ---- ppp_parallel_port.sv ----

`include "ppp_map.svh"

// small synchronous fifo, count based
module ppp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  // pointers and fill level
  typedef struct packed {
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [PW:0] count;
  } ppp_fifo_state_t;

  ppp_fifo_state_t s_reg; // registered pointers
  ppp_fifo_state_t s_next; // next pointers
  logic [WIDTH-1:0] store [DEPTH]; // storage words
  logic doPush; // word accepted
  logic doPop; // word delivered

  // honest flags straight from the fill level
  assign inReady = (s_reg.count != (PW+1)'(DEPTH));
  assign outValid = (s_reg.count != '0);
  assign outData = store[s_reg.rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // pointer arithmetic; wrap relies on a power-of-two depth
  always_comb begin
    s_next = s_reg;
    if (doPush) begin
      s_next.wrPtr = s_reg.wrPtr + 1'b1;
    end
    if (doPop) begin
      s_next.rdPtr = s_reg.rdPtr + 1'b1;
    end
    case ({doPush, doPop})
      2'b10: s_next.count = s_reg.count + 1'b1;
      2'b01: s_next.count = s_reg.count - 1'b1;
      default: s_next.count = s_reg.count;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage needs no reset, only valid words are read
  always_ff @(posedge clk) begin
    if (doPush) begin
      store[s_reg.wrPtr] <= inData;
    end
  end
endmodule

// parallel programming port of the nonvolatile arrays
module ppp_parallel_port #(
  parameter int unsigned WRITE_CYCLES = int'(`PPP_WRITE_CYCLES),
  parameter int unsigned ERASE_CYCLES = int'(`PPP_ERASE_CYCLES),
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // programmer control pins
  input wire logic loadStrobe,
  input wire logic actionSelHi,
  input wire logic actionSelLo,
  input wire logic byteSelectOne,
  input wire logic byteSelectTwo,
  input wire logic pageLatchPulse,
  input wire logic writeStrobeN,
  input wire logic outputEnableN,
  // bidirectional data bus as three signals
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // status
  output logic readyBusyOut
);
  ppp_pkg::ppp_regs_t r_reg; // all control state
  ppp_pkg::ppp_regs_t r_next; // next control state

  // the arrays themselves
  logic [15:0] flashMem [2**`PPP_FLASH_AW];
  logic [7:0] eeMem [2**`PPP_EE_AW];
  logic [15:0] pageBuf [2**`PPP_FWORD_BITS];

  // array write ports, filled by the controller
  logic flashWe;
  logic [`PPP_FLASH_AW-1:0] flashWa;
  logic [15:0] flashWd;
  logic eeWe;
  logic [`PPP_EE_AW-1:0] eeWa;
  logic [7:0] eeWd;

  // fifo between page latch and page buffer
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [`PPP_FIFO_W-1:0] fifoOutData;

  // decoded pin events
  logic strobeRise; // load strobe rising edge
  logic latchRise; // page latch rising edge
  logic writeFall; // write strobe falling edge
  logic busy; // any self-timed work in progress
  logic [`PPP_FLASH_AW-1:0] curFlash; // loaded flash word address
  logic [`PPP_EE_AW-1:0] curEe; // loaded eeprom byte address
  logic [15:0] rdWord; // flash word at loaded address
  logic [7:0] rdByte; // eeprom byte at loaded address
  logic [15:0] bufWord; // page buffer word under the walk

  // flash word address from the two loaded address bytes
  function automatic logic [`PPP_FLASH_AW-1:0] flashAddr(input logic [7:0] hi,
                                                          input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[`PPP_FLASH_AW-1:0];
  endfunction

  // eeprom byte address from the two loaded address bytes
  function automatic logic [`PPP_EE_AW-1:0] eeAddr(input logic [7:0] hi,
                                                    input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[`PPP_EE_AW-1:0];
  endfunction

  assign curFlash = flashAddr(r_reg.addrHi, r_reg.addrLo);
  assign curEe = eeAddr(r_reg.addrHi, r_reg.addrLo);
  assign rdWord = flashMem[curFlash];
  assign rdByte = eeMem[curEe];
  assign bufWord = pageBuf[r_reg.walk[`PPP_FWORD_BITS-1:0]];

  // pins are synchronous, so one previous sample gives the edges
  assign strobeRise = loadStrobe & ~r_reg.strobePrev;
  assign latchRise = pageLatchPulse & ~r_reg.latchPrev;
  assign writeFall = ~writeStrobeN & r_reg.writePrev;
  assign busy = (r_reg.state != ppp_pkg::ST_IDLE);

  // bus drive follows output enable directly, data is registered
  assign dataOe = ~outputEnableN;
  assign dataOut = r_reg.rdData;
  assign readyBusyOut = ~busy;

  // latched words enter the fifo; drain stalls while the page is walked
  assign fifoInValid = r_reg.latchPend;
  assign fifoOutReady = (r_reg.state != ppp_pkg::ST_PROG);

  ppp_fifo #(
    .WIDTH(`PPP_FIFO_W),
    .DEPTH(`PPP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({r_reg.pendIdx, r_reg.pendWord}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // page buffer fill from the fifo
  always_ff @(posedge clk) begin
    if (fifoOutValid && fifoOutReady) begin
      pageBuf[fifoOutData[21:16]] <= fifoOutData[15:0];
    end
  end

  // array write ports; no reset, contents are nonvolatile
  always_ff @(posedge clk) begin
    if (flashWe) begin
      flashMem[flashWa] <= flashWd;
    end
    if (eeWe) begin
      eeMem[eeWa] <= eeWd;
    end
  end

  // next-state logic of the whole port
  always_comb begin
    r_next = r_reg;
    flashWe = 1'b0;
    flashWa = '0;
    flashWd = `PPP_ERASED_WORD;
    eeWe = 1'b0;
    eeWa = '0;
    eeWd = `PPP_ERASED;
    r_next.strobePrev = loadStrobe;
    r_next.latchPrev = pageLatchPulse;
    r_next.writePrev = writeStrobeN;

    // load strobe: action bits pick the register, byte select one picks the high or low byte of address or data
    if (strobeRise) begin
      case ({actionSelHi, actionSelLo})
        `PPP_ACT_ADDR: begin
          if (byteSelectOne) begin
            r_next.addrHi = dataIn;
          end else begin
            r_next.addrLo = dataIn;
          end
        end
        `PPP_ACT_DATA: begin
          if (byteSelectOne) begin
            r_next.dataHi = dataIn;
          end else begin
            r_next.dataLo = dataIn;
          end
        end
        `PPP_ACT_CMD: begin
          // a running operation keeps its command
          if (!busy) begin
            r_next.cmd = dataIn;
          end
        end
        default: begin
          // idle code, nothing loaded
        end
      endcase
    end

    // a queued latch leaves once the fifo takes it
    if (r_reg.latchPend && fifoInReady) begin
      r_next.latchPend = 1'b0;
    end
    // page latch with high byte selected; a new latch wins over the clear
    if (latchRise && byteSelectOne) begin
      if (r_reg.cmd == `PPP_CMD_WFLASH) begin
        r_next.latchPend = 1'b1;
        r_next.pendIdx = r_reg.addrLo[5:0];
        r_next.pendWord = {r_reg.dataHi, r_reg.dataLo};
      end else if (r_reg.cmd == `PPP_CMD_WEEPROM) begin
        r_next.latchPend = 1'b1;
        r_next.pendIdx = {4'h0, r_reg.addrLo[`PPP_EWORD_BITS-1:0]};
        r_next.pendWord = {8'h00, r_reg.dataLo};
      end
    end

    // the timer runs through every busy state
    if (busy && (r_reg.timer != 18'h3FFFF)) begin
      r_next.timer = r_reg.timer + 18'h00001;
    end

    case (r_reg.state)
      ppp_pkg::ST_IDLE: begin
        // write strobe acts on the retained command and address
        if (writeFall) begin
          r_next.opCmd = r_reg.cmd;
          r_next.timer = '0;
          r_next.walk = '0;
          case (r_reg.cmd)
            `PPP_CMD_ERASE: begin
              r_next.state = ppp_pkg::ST_ERASE;
              r_next.erasePhase = 1'b0;
              // programmed preserve fuse reads as zero
              r_next.eraseEe = r_reg.fuseHi[`PPP_PRESERVE_BIT];
            end
            `PPP_CMD_WFLASH, `PPP_CMD_WEEPROM: begin
              if (!byteSelectOne) begin
                r_next.state = ppp_pkg::ST_DRAIN;
              end
            end
            `PPP_CMD_WFUSE: begin
              if (!byteSelectTwo) begin
                if (byteSelectOne) begin
                  r_next.fuseHi = r_reg.dataLo;
                end else begin
                  r_next.fuseLo = r_reg.dataLo;
                end
                r_next.state = ppp_pkg::ST_HOLD;
              end
            end
            `PPP_CMD_WLOCK: begin
              // a one never erases a programmed lock bit
              r_next.lockBits = r_reg.lockBits & r_reg.dataLo;
              r_next.state = ppp_pkg::ST_HOLD;
            end
            default: begin
              // reads and nop ignore the write strobe
            end
          endcase
        end
      end
      ppp_pkg::ST_DRAIN: begin
        // every latched word must be in the buffer before the walk
        if (!fifoOutValid && !r_reg.latchPend) begin
          r_next.state = ppp_pkg::ST_PROG;
        end
      end
      ppp_pkg::ST_PROG: begin
        // copy the buffer, one word a cycle, into the addressed page
        if (r_reg.opCmd == `PPP_CMD_WFLASH) begin
          flashWe = 1'b1;
          flashWa = {curFlash[`PPP_FLASH_AW-1:`PPP_FWORD_BITS],
                     r_reg.walk[`PPP_FWORD_BITS-1:0]};
          flashWd = bufWord;
          if (r_reg.walk == `PPP_FPAGE_LAST) begin
            r_next.state = ppp_pkg::ST_HOLD;
          end
        end else begin
          eeWe = 1'b1;
          eeWa = {curEe[`PPP_EE_AW-1:`PPP_EWORD_BITS],
                  r_reg.walk[`PPP_EWORD_BITS-1:0]};
          eeWd = bufWord[7:0];
          if (r_reg.walk == `PPP_EPAGE_LAST) begin
            r_next.state = ppp_pkg::ST_HOLD;
          end
        end
        r_next.walk = r_reg.walk + 14'h0001;
      end
      ppp_pkg::ST_ERASE: begin
        // flash first, then eeprom unless preserved, fuses untouched
        r_next.walk = r_reg.walk + 14'h0001;
        if (!r_reg.erasePhase) begin
          flashWe = 1'b1;
          flashWa = r_reg.walk[`PPP_FLASH_AW-1:0];
          if (r_reg.walk == `PPP_FLASH_LAST) begin
            r_next.walk = '0;
            r_next.erasePhase = 1'b1;
          end
        end else if (r_reg.eraseEe) begin
          eeWe = 1'b1;
          eeWa = r_reg.walk[`PPP_EE_AW-1:0];
        end
        // locks return to erased only once the arrays are done
        if (r_reg.erasePhase &&
            (!r_reg.eraseEe || (r_reg.walk == `PPP_EE_LAST))) begin
          r_next.lockBits = `PPP_LOCK_RST;
          r_next.state = ppp_pkg::ST_HOLD;
        end
      end
      ppp_pkg::ST_HOLD: begin
        // stay busy until the self-timed period has passed
        if (r_reg.opCmd == `PPP_CMD_ERASE) begin
          if ((32'(r_reg.timer) + 32'd1) >= ERASE_CYCLES) begin
            r_next.state = ppp_pkg::ST_IDLE;
          end
        end else if ((32'(r_reg.timer) + 32'd1) >= WRITE_CYCLES) begin
          r_next.state = ppp_pkg::ST_IDLE;
        end
      end
      default: begin
        r_next.state = ppp_pkg::ST_IDLE;
      end
    endcase

    // read path, registered one cycle behind the selects
    case (r_reg.cmd)
      `PPP_CMD_RFLASH: begin
        r_next.rdData = byteSelectOne ? rdWord[15:8] : rdWord[7:0];
      end
      `PPP_CMD_REEPROM: begin
        r_next.rdData = byteSelectOne ? `PPP_ERASED : rdByte;
      end
      `PPP_CMD_RFUSE: begin
        case ({byteSelectTwo, byteSelectOne})
          2'h0: r_next.rdData = r_reg.fuseLo;
          2'h3: r_next.rdData = r_reg.fuseHi;
          2'h1: r_next.rdData = r_reg.lockBits;
          default: r_next.rdData = `PPP_ERASED;
        endcase
      end
      `PPP_CMD_RSIG: begin
        if (byteSelectOne) begin
          // only one calibration byte exists, at address zero
          r_next.rdData = (r_reg.addrLo == 8'h00) ? CAL_BYTE : `PPP_ERASED;
        end else begin
          case (r_reg.addrLo)
            8'h00: r_next.rdData = SIG_BYTE0;
            8'h01: r_next.rdData = SIG_BYTE1;
            8'h02: r_next.rdData = SIG_BYTE2;
            default: r_next.rdData = `PPP_ERASED;
          endcase
        end
      end
      default: begin
        r_next.rdData = `PPP_ERASED;
      end
    endcase
  end

  // state register; fuses come up at their default pattern
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
      r_reg.state <= ppp_pkg::ST_IDLE;
      r_reg.fuseLo <= `PPP_FUSE_LO_RST;
      r_reg.fuseHi <= `PPP_FUSE_HI_RST;
      r_reg.lockBits <= `PPP_LOCK_RST;
      r_reg.rdData <= `PPP_ERASED;
      r_reg.writePrev <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// ---- ppp_assertions.sv ----
`include "ppp_map.svh"

// watches the port pins and checks busy timing, bus enable and id reads
module ppp_checker #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // programmer pins
  input wire logic loadStrobe,
  input wire logic actionSelHi,
  input wire logic actionSelLo,
  input wire logic byteSelectOne,
  input wire logic byteSelectTwo,
  input wire logic pageLatchPulse,
  input wire logic writeStrobeN,
  input wire logic outputEnableN,
  // bus and status
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic readyBusyOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic strobeQ, wrQ, wrFall;
  logic [7:0] cmdSeen; // command as the port should hold it
  logic [7:0] addrSeen; // low address byte
  logic [15:0] busyCnt; // length of the current busy stretch

  // shadow of command and low address; commands are dropped while busy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobeQ <= 1'b0;
      wrQ <= 1'b1;
      cmdSeen <= 8'h00;
      addrSeen <= 8'h00;
      busyCnt <= 16'h0000;
    end else begin
      strobeQ <= loadStrobe;
      wrQ <= writeStrobeN;
      busyCnt <= readyBusyOut ? 16'h0000 : busyCnt + 16'h0001;
      if (loadStrobe && !strobeQ) begin
        if ({actionSelHi, actionSelLo} == `PPP_ACT_CMD && readyBusyOut) cmdSeen <= dataIn;
        if ({actionSelHi, actionSelLo} == `PPP_ACT_ADDR && !byteSelectOne) addrSeen <= dataIn;
      end
    end
  end
  assign wrFall = wrQ && !writeStrobeN;

  // id reads need settled selects for three cycles
  sequence s_idSel(logic bs1);
    (cmdSeen == `PPP_CMD_RSIG && addrSeen == 8'h00 && byteSelectOne == bs1
      && !outputEnableN)[*3];
  endsequence
  sequence s_start(logic [7:0] c);
    wrFall && readyBusyOut && cmdSeen == c;
  endsequence

  property p_oe; dataOe == !outputEnableN; endproperty
  property p_flash; s_start(`PPP_CMD_WFLASH) ##0 !byteSelectOne |=> !readyBusyOut; endproperty
  property p_hiSel; s_start(`PPP_CMD_WFLASH) ##0 byteSelectOne |=> readyBusyOut; endproperty
  property p_ee; s_start(`PPP_CMD_WEEPROM) ##0 !byteSelectOne |=> !readyBusyOut; endproperty
  property p_erase; s_start(`PPP_CMD_ERASE) |=> !readyBusyOut; endproperty
  property p_nop; s_start(`PPP_CMD_NOP) |=> readyBusyOut; endproperty
  property p_hold; $fell(readyBusyOut) |-> !readyBusyOut[*8]; endproperty
  property p_bound; busyCnt < 16'd20000; endproperty
  property p_sig; s_idSel(1'b0) |-> dataOut == SIG_BYTE0; endproperty
  property p_cal; s_idSel(1'b1) |-> dataOut == CAL_BYTE; endproperty

  a_oe: assert property (p_oe) else $error("bus enable wrong");
  a_flash: assert property (p_flash) else $error("flash write not busy");
  a_hiSel: assert property (p_hiSel) else $error("flash write with high select");
  a_ee: assert property (p_ee) else $error("eeprom write not busy");
  a_erase: assert property (p_erase) else $error("erase not busy");
  a_nop: assert property (p_nop) else $error("write after nop went busy");
  a_hold: assert property (p_hold) else $error("busy too short");
  a_bound: assert property (p_bound) else $error("busy never ends");
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  a_cal: assert property (p_cal) else $error("calibration byte wrong");
endmodule

bind ppp_parallel_port ppp_checker #(.SIG_BYTE0(SIG_BYTE0), .CAL_BYTE(CAL_BYTE)) chk (
  .clk(clk), .rstn(rstn), .loadStrobe(loadStrobe), .actionSelHi(actionSelHi),
  .actionSelLo(actionSelLo), .byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
  .pageLatchPulse(pageLatchPulse), .writeStrobeN(writeStrobeN),
  .outputEnableN(outputEnableN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
  .readyBusyOut(readyBusyOut));

// ---- ppp_programmer.sv ----
// external programmer: drives the pins and its half of the data wire
module ppp_programmer (
  // clock
  input wire logic clk,
  // control pins
  output logic loadStrobe,
  output logic actionSelHi,
  output logic actionSelLo,
  output logic byteSelectOne,
  output logic byteSelectTwo,
  output logic pageLatchPulse,
  output logic writeStrobeN,
  output logic outputEnableN,
  // shared data wire
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  output logic [7:0] busLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drvEn; // programmer drives the wire
  logic [7:0] drvData, lastBus;

  initial begin
    {loadStrobe, actionSelHi, actionSelLo, byteSelectOne, byteSelectTwo} = 5'h00;
    {pageLatchPulse, writeStrobeN, outputEnableN, drvEn} = 4'h6;
    drvData = 8'h00;
    lastBus = 8'h00;
  end
  // a released wire shows the inverse of its last level, never a kind guess
  always @(posedge clk) lastBus <= busLevel;
  assign busLevel = dataOe ? dataOut : (drvEn ? drvData : ~lastBus);

  // one byte load: set up, strobe high a cycle, hold a cycle after
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] b);
    @(posedge clk);
    {actionSelHi, actionSelLo} <= act;
    byteSelectOne <= bs1;
    outputEnableN <= 1'b1;
    drvData <= b;
    drvEn <= 1'b1;
    @(posedge clk);
    loadStrobe <= 1'b1;
    @(posedge clk);
    loadStrobe <= 1'b0;
    @(posedge clk);
    drvEn <= 1'b0;
  endtask
  // page latch always with high byte select
  task automatic latch();
    @(posedge clk);
    byteSelectOne <= 1'b1;
    @(posedge clk);
    pageLatchPulse <= 1'b1;
    @(posedge clk);
    pageLatchPulse <= 1'b0;
  endtask
  // low write pulse with given selects
  task automatic wr(input logic bs1, input logic bs2);
    @(posedge clk);
    {byteSelectOne, byteSelectTwo} <= {bs1, bs2};
    @(posedge clk);
    writeStrobeN <= 1'b0;
    @(posedge clk);
    writeStrobeN <= 1'b1;
    @(posedge clk);
  endtask
  task automatic sel(input logic bs2, input logic bs1, input logic oeN);
    @(posedge clk);
    {byteSelectTwo, byteSelectOne, outputEnableN} <= {bs2, bs1, oeN};
  endtask
endmodule

// ---- ppp_parallel_port_tb.sv ----
`include "ppp_map.svh"

module ppp_parallel_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SIG0 = 8'h4D; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h2B; // arbitrary value
  localparam logic [7:0] SIG2 = 8'h71; // arbitrary value
  localparam logic [7:0] CAL = 8'h6E;
  logic clk = 1'b0, rstn = 1'b0, take = 1'b0;
  logic loadStrobe, actionSelHi, actionSelLo, byteSelectOne, byteSelectTwo;
  logic pageLatchPulse, writeStrobeN, outputEnableN, dataOe, readyBusyOut;
  logic [7:0] dataIn, dataOut;
  logic [8:0] expQ[$]; // bit 8 marks a ready check
  logic [7:0] sig[3];
  logic [15:0] word[2];
  logic [31:0] seed = 32'h4AE7;
  int n_mismatch = 0, checks = 0, cycles = 0;

  always #20 clk = ~clk;

  ppp_programmer prog (.clk(clk), .loadStrobe(loadStrobe), .actionSelHi(actionSelHi),
    .actionSelLo(actionSelLo), .byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
    .pageLatchPulse(pageLatchPulse), .writeStrobeN(writeStrobeN),
    .outputEnableN(outputEnableN), .dataOut(dataOut), .dataOe(dataOe), .busLevel(dataIn));
  // short write and erase times keep the run small
  ppp_parallel_port #(.WRITE_CYCLES(200), .ERASE_CYCLES(200), .SIG_BYTE0(SIG0),
    .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) DUT (.clk(clk), .rstn(rstn),
    .loadStrobe(loadStrobe), .actionSelHi(actionSelHi), .actionSelLo(actionSelLo),
    .byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
    .pageLatchPulse(pageLatchPulse), .writeStrobeN(writeStrobeN),
    .outputEnableN(outputEnableN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .readyBusyOut(readyBusyOut));

  function logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // monitor: oldest note against what the port shows now
  always @(posedge clk) begin
    if (take === 1'b1) begin
      logic [8:0] e;
      e = expQ.pop_front();
      checks++;
      if (e[8] ? (readyBusyOut !== e[0]) : (dataOut !== e[7:0])) begin
        $display("wrong value %s expected %h seen %h", e[8] ? "readyBusyOut" : "dataOut",
          e[7:0], e[8] ? {7'h00, readyBusyOut} : dataOut);
        n_mismatch++;
      end
    end
  end

  task automatic note(input logic [8:0] e);
    expQ.push_back(e);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
  endtask
  task automatic rd(input logic bs2, input logic bs1, input logic [7:0] e);
    prog.sel(bs2, bs1, 1'b0);
    repeat (3) @(posedge clk);
    note({1'b0, e});
  endtask
  task automatic rdy(input logic e);
    note({1'b1, 7'h00, e});
  endtask
  task automatic cmd(input logic [7:0] c);
    prog.load(`PPP_ACT_CMD, 1'b0, c);
  endtask
  // bounded wait, sampled after the edge has settled
  task automatic waitReady();
    int n;
    n = 0;
    #1;
    while (readyBusyOut !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30000) begin
      $display("wrong value readyBusyOut expected 1 seen %b", readyBusyOut);
      n_mismatch++;
    end
  endtask
  task automatic wrWait(input logic bs1, input logic bs2);
    prog.wr(bs1, bs2);
    waitReady();
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well above the erase walk
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    sig = '{SIG0, SIG1, SIG2};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // reset fuse values and id bytes
    cmd(`PPP_CMD_RFUSE);
    rd(1'b0, 1'b0, `PPP_FUSE_LO_RST);
    rd(1'b1, 1'b1, `PPP_FUSE_HI_RST);
    rd(1'b0, 1'b1, `PPP_LOCK_RST);
    cmd(`PPP_CMD_RSIG);
    for (int i = 0; i < 3; i++) begin
      prog.load(`PPP_ACT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i]);
    end
    prog.load(`PPP_ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 1'b1, CAL);
    $display("test ident done");
    // first and last word of page 6, command load refused while busy
    cmd(`PPP_CMD_WFLASH);
    for (int i = 0; i < 2; i++) begin
      word[i] = 16'(xorshift());
      prog.load(`PPP_ACT_ADDR, 1'b0, i ? 8'hBF : 8'h80);
      prog.load(`PPP_ACT_DATA, 1'b0, word[i][7:0]);
      prog.load(`PPP_ACT_DATA, 1'b1, word[i][15:8]);
      prog.latch();
    end
    prog.load(`PPP_ACT_ADDR, 1'b1, 8'h01);
    prog.wr(1'b1, 1'b0);
    rdy(1'b1);
    prog.wr(1'b0, 1'b0);
    rdy(1'b0);
    cmd(`PPP_CMD_RFLASH);
    waitReady();
    rd(1'b0, 1'b0, 8'hFF);
    cmd(`PPP_CMD_RFLASH);
    for (int i = 0; i < 2; i++) begin
      prog.load(`PPP_ACT_ADDR, 1'b0, i ? 8'hBF : 8'h80);
      rd(1'b0, 1'b0, word[i][7:0]);
      rd(1'b0, 1'b1, word[i][15:8]);
    end
    cmd(`PPP_CMD_NOP);
    prog.wr(1'b0, 1'b0);
    rdy(1'b1);
    $display("test flash done");
    // one eeprom page
    cmd(`PPP_CMD_WEEPROM);
    prog.load(`PPP_ACT_ADDR, 1'b1, 8'h02);
    for (int i = 0; i < 4; i++) begin
      prog.load(`PPP_ACT_ADDR, 1'b0, 8'h08 | 8'(i));
      prog.load(`PPP_ACT_DATA, 1'b0, 8'hC0 | 8'(i));
      prog.latch();
    end
    prog.wr(1'b0, 1'b0);
    rdy(1'b0);
    waitReady();
    cmd(`PPP_CMD_REEPROM);
    for (int i = 0; i < 4; i++) begin
      prog.load(`PPP_ACT_ADDR, 1'b0, 8'h08 | 8'(i));
      rd(1'b0, 1'b0, 8'hC0 | 8'(i));
    end
    $display("test eeprom done");
    // fuses (preserve bit programmed), refused select, locks only program
    cmd(`PPP_CMD_WFUSE);
    prog.load(`PPP_ACT_DATA, 1'b0, 8'hD3);
    wrWait(1'b0, 1'b0);
    prog.load(`PPP_ACT_DATA, 1'b0, 8'h91);
    wrWait(1'b1, 1'b0);
    prog.load(`PPP_ACT_DATA, 1'b0, 8'h00);
    prog.wr(1'b0, 1'b1);
    rdy(1'b1);
    cmd(`PPP_CMD_WLOCK);
    prog.load(`PPP_ACT_DATA, 1'b0, 8'hF0);
    wrWait(1'b0, 1'b0);
    prog.load(`PPP_ACT_DATA, 1'b0, 8'hFF);
    wrWait(1'b0, 1'b0);
    cmd(`PPP_CMD_RFUSE);
    rd(1'b0, 1'b0, 8'hD3);
    rd(1'b1, 1'b1, 8'h91);
    rd(1'b0, 1'b1, 8'hF0);
    $display("test fuse done");
    // chip erase keeps fuses and, with preserve set, eeprom
    cmd(`PPP_CMD_ERASE);
    prog.wr(1'b0, 1'b0);
    rdy(1'b0);
    waitReady();
    cmd(`PPP_CMD_RFUSE);
    rd(1'b0, 1'b0, 8'hD3);
    rd(1'b1, 1'b1, 8'h91);
    rd(1'b0, 1'b1, `PPP_LOCK_RST);
    cmd(`PPP_CMD_REEPROM);
    prog.load(`PPP_ACT_ADDR, 1'b1, 8'h02);
    prog.load(`PPP_ACT_ADDR, 1'b0, 8'h08);
    rd(1'b0, 1'b0, 8'hC0);
    cmd(`PPP_CMD_RFLASH);
    prog.load(`PPP_ACT_ADDR, 1'b1, 8'h01);
    prog.load(`PPP_ACT_ADDR, 1'b0, 8'h80);
    rd(1'b0, 1'b0, 8'hFF);
    rd(1'b0, 1'b1, 8'hFF);
    $display("test erase done");
    end_of_test();
  end
endmodule
